// File: dcf_core.sv
// buffer core: 512 x 36 store, port A write side, port B read side, offset programming
// assumes one reference clock for both ports; port controls are synchronous to it
`timescale 1ns/10ps

module dcf_skid_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic [AW:0] used;

  assign used = wr_r - rd_r;
  assign in_ready_o = (used < (AW+1)'(DEPTH));
  assign out_valid_o = (used != '0);
  assign out_data_o = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (in_valid_i && in_ready_o) begin
      mem[wr_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_r <= '0;
    end else if (in_valid_i && in_ready_o) begin
      wr_r <= wr_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_r <= '0;
    end else if (out_valid_o && out_ready_i) begin
      rd_r <= rd_r + 1'b1;
    end
  end
endmodule

module dcf_core
  import dcf_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic PRESET_SELECT_LO_I,
  input wire logic PRESET_SELECT_HI_I,
  input wire logic SERIAL_OFFSET_BIT_I,
  input wire logic SERIAL_LOAD_STROBE_N_I,
  input wire logic PORT_A_SELECT_N_I,
  input wire logic PORT_A_DIRECTION_I,
  input wire logic PORT_A_STROBE_I,
  input wire logic PORT_A_MAIL_SELECT_I,
  input wire logic [DATA_W-1:0] PORT_A_BUS_I,
  output logic [DATA_W-1:0] PORT_A_BUS_O,
  output logic PORT_A_BUS_OE_N_O,
  input wire logic PORT_B_SELECT_N_I,
  input wire logic PORT_B_DIRECTION_I,
  input wire logic PORT_B_STROBE_I,
  input wire logic PORT_B_MAIL_SELECT_I,
  output logic [DATA_W-1:0] PORT_B_BUS_O,
  output logic PORT_B_BUS_OE_N_O,
  output logic INPUT_READY_O,
  output logic OUTPUT_READY_O,
  output logic ALMOST_EMPTY_FLAG_O,
  output logic ALMOST_FULL_FLAG_O,
  output logic MAIL_TO_B_FULL_N_O,
  output logic MAIL_TO_A_FULL_N_O
);
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    gray2bin = b;
  endfunction

  logic [DATA_W-1:0] store [2**ADDR_W];

  // preset selects are asynchronous straps
  logic sel_lo_s1_r;
  logic sel_lo_s2_r;
  logic sel_hi_s1_r;
  logic sel_hi_s2_r;

  dcf_state_t st_r;
  logic [1:0] wait_cnt_r;
  logic [4:0] ser_cnt_r;
  logic [SER_BITS-1:0] ser_sh_r;
  logic [1:0] par_left_r;
  logic [OFS_W-1:0] ofs_empty_r;
  logic [OFS_W-1:0] ofs_full_r;

  logic [PTR_W-1:0] wptr_r;
  logic [PTR_W-1:0] wptr_gray_r;
  logic [PTR_W-1:0] rptr_r;
  logic [PTR_W-1:0] rptr_gray_r;
  logic [PTR_W-1:0] rg_s1_r;
  logic [PTR_W-1:0] rg_s2_r;
  logic [PTR_W-1:0] wg_s1_r;
  logic [PTR_W-1:0] wg_s2_r;
  logic [PTR_W-1:0] wr_count;
  logic [PTR_W-1:0] rd_count;

  logic af_r;
  logic ae_r;
  logic or_r;
  logic [DATA_W-1:0] out_r;

  logic wr_req;
  logic rd_req;
  logic advance;
  logic skid_in_valid;
  logic skid_in_ready;
  logic skid_out_valid;
  logic skid_out_ready;
  logic [DATA_W-1:0] skid_out_data;
  logic ser_last;
  dcf_mode_t strap_mode;

  always_ff @(posedge REF_CLK_I) begin
    sel_lo_s1_r <= PRESET_SELECT_LO_I;
    sel_lo_s2_r <= sel_lo_s1_r;
    sel_hi_s1_r <= PRESET_SELECT_HI_I;
    sel_hi_s2_r <= sel_hi_s1_r;
  end

  assign strap_mode = dcf_mode_t'({sel_hi_s2_r, sel_lo_s2_r});
  assign ser_last = !SERIAL_LOAD_STROBE_N_I && (ser_cnt_r == SER_BITS - 5'h01);

  // start-up sequencing; the first edge with reset low is the release
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      st_r <= ST_RESET;
      wait_cnt_r <= 2'h0;
    end else begin
      case (st_r)
        ST_RESET: begin
          st_r <= (strap_mode == MODE_SERIAL) ? ST_SERIAL : ST_WAIT;
          wait_cnt_r <= 2'h1;
        end
        ST_WAIT: begin
          wait_cnt_r <= wait_cnt_r + 2'h1;
          if (wait_cnt_r >= START_CYCLES - 2'h1) begin
            st_r <= ST_RUN;
          end
        end
        ST_SERIAL: begin
          if (ser_last) begin
            st_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          st_r <= ST_RUN;
        end
        default: begin
          st_r <= ST_RESET;
        end
      endcase
    end
  end

  // serial offset shifting, almost-full msb first
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      ser_cnt_r <= 5'h00;
      ser_sh_r <= '0;
    end else if (st_r == ST_SERIAL && !SERIAL_LOAD_STROBE_N_I) begin
      ser_cnt_r <= ser_cnt_r + 5'h01;
      ser_sh_r <= {ser_sh_r[SER_BITS-2:0], SERIAL_OFFSET_BIT_I};
    end
  end

  // offset registers
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      ofs_empty_r <= OFS_RESET;
      ofs_full_r <= OFS_RESET;
    end else if (st_r == ST_RESET && strap_mode == MODE_PRESET_SMALL) begin
      ofs_empty_r <= PRESET_SMALL;
      ofs_full_r <= PRESET_SMALL;
    end else if (st_r == ST_RESET && strap_mode == MODE_PRESET_LARGE) begin
      ofs_empty_r <= PRESET_LARGE;
      ofs_full_r <= PRESET_LARGE;
    end else if (ser_last && st_r == ST_SERIAL) begin
      ofs_full_r <= ser_sh_r[SER_BITS-2:OFS_W-1];
      ofs_empty_r <= {ser_sh_r[OFS_W-2:0], SERIAL_OFFSET_BIT_I};
    end else if (wr_req && par_left_r == PARALLEL_WORDS) begin
      ofs_full_r <= PORT_A_BUS_I[OFS_W-1:0];
    end else if (wr_req && par_left_r == 2'h1) begin
      ofs_empty_r <= PORT_A_BUS_I[OFS_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      par_left_r <= 2'h0;
    end else if (st_r == ST_RESET) begin
      par_left_r <= (strap_mode == MODE_PARALLEL) ? PARALLEL_WORDS : 2'h0;
    end else if (wr_req && par_left_r != 2'h0) begin
      par_left_r <= par_left_r - 2'h1;
    end
  end

  // port A: write side
  assign INPUT_READY_O = (st_r == ST_RUN) && skid_in_ready;
  assign wr_req = !PORT_A_SELECT_N_I && !PORT_A_MAIL_SELECT_I && PORT_A_DIRECTION_I
                  && PORT_A_STROBE_I && INPUT_READY_O;
  assign skid_in_valid = wr_req && (par_left_r == 2'h0);
  assign skid_out_ready = (st_r == ST_RUN) && (wr_count < DEPTH);
  assign PORT_A_BUS_OE_N_O = !(!PORT_A_SELECT_N_I && !PORT_A_DIRECTION_I);
  assign PORT_A_BUS_O = '0;

  dcf_skid_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(SKID_DEPTH)
  ) u_skid (
    .clk_i(REF_CLK_I),
    .reset_i(RESET_I),
    .in_valid_i(skid_in_valid),
    .in_ready_o(skid_in_ready),
    .in_data_i(PORT_A_BUS_I),
    .out_valid_o(skid_out_valid),
    .out_ready_i(skid_out_ready),
    .out_data_o(skid_out_data)
  );

  always_ff @(posedge REF_CLK_I) begin
    if (skid_out_valid && skid_out_ready) begin
      store[wptr_r[ADDR_W-1:0]] <= skid_out_data;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      wptr_r <= '0;
      wptr_gray_r <= '0;
    end else if (skid_out_valid && skid_out_ready) begin
      wptr_r <= wptr_r + 1'b1;
      wptr_gray_r <= bin2gray(wptr_r + 1'b1);
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end else begin
      rg_s1_r <= rptr_gray_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  assign wr_count = wptr_r - gray2bin(rg_s2_r);

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      af_r <= 1'b1;
    end else begin
      af_r <= !(wr_count >= DEPTH - {1'b0, ofs_full_r});
    end
  end

  // port B: read side
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      wg_s1_r <= wptr_gray_r;
      wg_s2_r <= wg_s1_r;
    end
  end

  assign rd_count = gray2bin(wg_s2_r) - rptr_r;
  assign rd_req = !PORT_B_SELECT_N_I && !PORT_B_MAIL_SELECT_I && PORT_B_DIRECTION_I
                  && PORT_B_STROBE_I && or_r;
  assign advance = (rd_count != '0) && (!or_r || rd_req);

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      rptr_r <= '0;
      rptr_gray_r <= '0;
      or_r <= 1'b0;
      out_r <= '0;
    end else if (advance) begin
      out_r <= store[rptr_r[ADDR_W-1:0]];
      rptr_r <= rptr_r + 1'b1;
      rptr_gray_r <= bin2gray(rptr_r + 1'b1);
      or_r <= 1'b1;
    end else if (rd_req) begin
      or_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      ae_r <= 1'b0;
    end else begin
      ae_r <= rd_count > {1'b0, ofs_empty_r};
    end
  end

  assign OUTPUT_READY_O = or_r;
  assign ALMOST_EMPTY_FLAG_O = ae_r;
  assign ALMOST_FULL_FLAG_O = af_r;
  assign PORT_B_BUS_O = out_r;
  assign PORT_B_BUS_OE_N_O = !(!PORT_B_SELECT_N_I && PORT_B_DIRECTION_I);
  // mailbox transfer is absent; flags stay inactive
  assign MAIL_TO_B_FULL_N_O = 1'b1;
  assign MAIL_TO_A_FULL_N_O = 1'b1;
endmodule

// File: dcf_pkg.sv
// Function
// - reset may assert and release at any moment.
// - reset clears pointers, input/output ready low, almost-empty low, almost-full high.
// - reset forces both mailbox full flags high, inactive.
// - input ready rises only after two clocks following reset release.
// - flag selects sampled at reset release choose offset load method.
// - select codes: 11 serial, 10 preset 64, 01 preset 8, 00 parallel.
// - preset loads both offsets, input ready rises after two edges.
// - parallel mode: first two writes load almost-full then almost-empty offsets.
// - parallel load takes low port-A bits, highest bit is msb.
// - serial mode shifts one bit per edge while serial strobe is low.
// - serial load takes exactly 18 bits for both offsets.
// - serial order: almost-full msb first, almost-empty lsb last.
// - input ready stays low during serial load, rises after last bit.
// - port-A bus driven only when select and direction both low.
// - buffer write on select, mail-select low with direction, strobe, ready high.
// - port-B bus driven only when select low and direction high.
// - buffer read on select, mail-select low with direction, strobe, ready high.
// - writes and reads proceed independently of each other.
// - prefetch into output register when output ready is low.
// - status flags pass two flip-flop stages before the output.
// - almost-empty low at offset words or fewer, high above.
// - almost-full low when count at least depth minus offset.
// package: constants and types of the buffer core; no assumptions on surroundings
package dcf_pkg;
  localparam int DATA_W = 36;
  localparam int ADDR_W = 9;
  localparam int PTR_W = 10;
  localparam int OFS_W = 9;
  localparam logic [PTR_W-1:0] DEPTH = 10'h200;
  localparam int SKID_DEPTH = 4;
  localparam logic [OFS_W-1:0] PRESET_SMALL = 9'h008;
  localparam logic [OFS_W-1:0] PRESET_LARGE = 9'h040;
  localparam logic [4:0] SER_BITS = 5'h12;
  localparam logic [1:0] START_CYCLES = 2'h2;
  localparam logic [1:0] PARALLEL_WORDS = 2'h2;
  localparam logic [OFS_W-1:0] OFS_RESET = 9'h000;

  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'b00,
    MODE_PRESET_SMALL = 2'b01,
    MODE_PRESET_LARGE = 2'b10,
    MODE_SERIAL = 2'b11
  } dcf_mode_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_WAIT = 2'b01,
    ST_SERIAL = 2'b10,
    ST_RUN = 2'b11
  } dcf_state_t;
endpackage

// File: dcf_core_properties.sv
// checker: port-level properties of the buffer core
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module dcf_core_properties import dcf_pkg::*; (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic PORT_A_SELECT_N_I,
  input wire logic PORT_A_DIRECTION_I,
  input wire logic PORT_A_BUS_OE_N_O,
  input wire logic PORT_B_SELECT_N_I,
  input wire logic PORT_B_DIRECTION_I,
  input wire logic PORT_B_STROBE_I,
  input wire logic PORT_B_MAIL_SELECT_I,
  input wire logic [DATA_W-1:0] PORT_B_BUS_O,
  input wire logic PORT_B_BUS_OE_N_O,
  input wire logic INPUT_READY_O,
  input wire logic OUTPUT_READY_O,
  input wire logic ALMOST_EMPTY_FLAG_O,
  input wire logic ALMOST_FULL_FLAG_O,
  input wire logic MAIL_TO_B_FULL_N_O,
  input wire logic MAIL_TO_A_FULL_N_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  logic rd;
  assign rd = !PORT_B_SELECT_N_I && !PORT_B_MAIL_SELECT_I && PORT_B_DIRECTION_I && PORT_B_STROBE_I;
  port_a_drive_a: assert property (
    PORT_A_BUS_OE_N_O == (PORT_A_SELECT_N_I || PORT_A_DIRECTION_I)) else $error("port A drive wrong");
  port_b_drive_a: assert property (
    PORT_B_BUS_OE_N_O == (PORT_B_SELECT_N_I || !PORT_B_DIRECTION_I)) else $error("port B drive wrong");
  mail_idle_a: assert property (
    disable iff (1'b0) MAIL_TO_B_FULL_N_O && MAIL_TO_A_FULL_N_O) else $error("mail flag low");
  reset_flags_a: assert property (
    disable iff (1'b0) RESET_I |=> !INPUT_READY_O && !OUTPUT_READY_O && !ALMOST_EMPTY_FLAG_O && ALMOST_FULL_FLAG_O)
    else $error("reset flags wrong");
  ready_wait_a: assert property (
    $fell(RESET_I) |-> !INPUT_READY_O [*2]) else $error("input ready too early");
  output_hold_a: assert property (
    OUTPUT_READY_O && !rd |=> $stable(PORT_B_BUS_O) && OUTPUT_READY_O) else $error("output moved unread");
  prefetch_only_a: assert property (
    !OUTPUT_READY_O |=> OUTPUT_READY_O || $stable(PORT_B_BUS_O)) else $error("output moved while not ready");
  sync_delay_a: assert property (
    $rose(OUTPUT_READY_O) |-> $past(INPUT_READY_O, 3)) else $error("output ready too soon");
  cover property (rd && OUTPUT_READY_O);
  cover property ($rose(ALMOST_EMPTY_FLAG_O));
  cover property ($fell(ALMOST_FULL_FLAG_O));
endmodule

bind dcf_core dcf_core_properties u_dcf_core_properties (.*);

// File: dcf_reader.sv
// port B host model: reads a word whenever not stalled
// assumes the core's port B pins and one shared clock
`timescale 1ns/10ps
module dcf_reader import dcf_pkg::*; (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic ready_i,
  input wire logic oe_n_i,
  input wire logic [DATA_W-1:0] bus_i,
  output logic select_n_o,
  output logic direction_o,
  output logic strobe_o,
  output logic mail_o
);
  logic [DATA_W-1:0] got[$];
  initial begin
    select_n_o = 1'b0;
    direction_o = 1'b1;
    mail_o = 1'b0;
  end
  always @(negedge clk_i) strobe_o <= !stall_i;
  // word counts as read only while driven and ready
  always @(posedge clk_i) begin
    if (strobe_o && ready_i && !oe_n_i) got.push_back(bus_i);
  end
endmodule

// File: testbench.sv
// testbench: offset modes, flag thresholds and data order
// assumes the core's single clock and synchronous reset
`timescale 1ns/10ps
module testbench import dcf_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, lo = 1'b0, hi = 1'b0, sbit = 1'b0, sen_n = 1'b1, stall = 1'b1;
  logic a_sel_n = 1'b1, a_dir = 1'b0, a_stb = 1'b0, a_mail = 1'b0;
  logic [DATA_W-1:0] a_bus = '0, a_out, b_bus;
  logic b_sel_n, b_dir, b_stb, b_mail, a_oe_n, b_oe_n, ir, orr, ae, af, mb_b, mb_a;
  logic [DATA_W-1:0] exp_q[$];
  int err_count = 0, total_checks = 0;
  initial forever #10 clk = ~clk;
  dcf_core u_dcf_core (.REF_CLK_I(clk), .RESET_I(rst), .PRESET_SELECT_LO_I(lo), .PRESET_SELECT_HI_I(hi),
    .SERIAL_OFFSET_BIT_I(sbit), .SERIAL_LOAD_STROBE_N_I(sen_n), .PORT_A_SELECT_N_I(a_sel_n),
    .PORT_A_DIRECTION_I(a_dir), .PORT_A_STROBE_I(a_stb), .PORT_A_MAIL_SELECT_I(a_mail),
    .PORT_A_BUS_I(a_bus), .PORT_A_BUS_O(a_out), .PORT_A_BUS_OE_N_O(a_oe_n), .PORT_B_SELECT_N_I(b_sel_n),
    .PORT_B_DIRECTION_I(b_dir), .PORT_B_STROBE_I(b_stb), .PORT_B_MAIL_SELECT_I(b_mail),
    .PORT_B_BUS_O(b_bus), .PORT_B_BUS_OE_N_O(b_oe_n), .INPUT_READY_O(ir), .OUTPUT_READY_O(orr),
    .ALMOST_EMPTY_FLAG_O(ae), .ALMOST_FULL_FLAG_O(af), .MAIL_TO_B_FULL_N_O(mb_b), .MAIL_TO_A_FULL_N_O(mb_a));
  dcf_reader u_dcf_reader (.clk_i(clk), .stall_i(stall), .ready_i(orr), .oe_n_i(b_oe_n), .bus_i(b_bus),
    .select_n_o(b_sel_n), .direction_o(b_dir), .strobe_o(b_stb), .mail_o(b_mail));
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // holds strobe and data until input ready is sampled high
  task automatic put(logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge clk);
    a_sel_n = 1'b0;
    a_dir = 1'b1;
    a_stb = 1'b1;
    a_bus = d;
    do @(posedge clk); while (ir !== 1'b1 && ++n < 50);
    chk("put_ready", 36'h1, DATA_W'(ir));
  endtask
  task automatic wr();
    exp_q.push_back({4'hc, ~32'(exp_q.size())});
    put(exp_q[$]);
  endtask
  task automatic idle();
    @(negedge clk);
    a_stb = 1'b0;
    a_dir = 1'b0;
  endtask
  task automatic flags(logic [1:0] e);
    idle();
    repeat (20) @(negedge clk);
    chk("ae_af", DATA_W'(e), DATA_W'({ae, af}));
  endtask
  initial begin
    #(20 * 20000);
    err_count++;
    print_verdict();
  end
  initial begin
    dcf_mode_t m;
    logic [OFS_W-1:0] x, y;
    logic [2*OFS_W-1:0] yx;
    int n;
    for (int k = 0; k < 4; k++) begin
      m = dcf_mode_t'(2'(3 - k));
      x = m == MODE_SERIAL ? 9'h004 : m == MODE_PARALLEL ? 9'h003 : m == MODE_PRESET_SMALL ? 9'h008 : 9'h040;
      y = m == MODE_SERIAL ? 9'h006 : m == MODE_PARALLEL ? 9'h005 : x;
      exp_q.delete();
      u_dcf_reader.got.delete();
      @(negedge clk);
      rst = 1'b1;
      {hi, lo} = m;
      stall = 1'b1;
      repeat (20) @(negedge clk);
      chk("reset_flags", DATA_W'(6'h07), DATA_W'({ir, orr, ae, af, mb_b, mb_a}));
      rst = 1'b0;
      @(negedge clk);
      chk("ready_early", '0, DATA_W'(ir));
      if (m == MODE_SERIAL) begin
        yx = {y, x};
        for (int i = 17; i >= 0; i--) begin
          @(negedge clk);
          chk("ready_serial", '0, DATA_W'(ir));
          sen_n = 1'b0;
          sbit = yx[i];
        end
        @(negedge clk);
        sen_n = 1'b1;
        chk("ready_serial_end", 36'h1, DATA_W'(ir));
      end else begin
        @(negedge clk);
        chk("ready_start", 36'h1, DATA_W'(ir));
      end
      if (m == MODE_PARALLEL) begin
        put({27'h2aaaaaa, y});
        put({27'h1555555, x});
      end
      repeat (x + 1) wr();
      flags(2'b01);
      chk("a_drive", '0, DATA_W'(a_oe_n));
      chk("a_bus", '0, a_out);
      wr();
      flags(2'b11);
      while (exp_q.size() < 512 - y) wr();
      flags(2'b11);
      wr();
      flags(2'b10);
      stall = 1'b0;
      repeat (3) wr();
      idle();
      for (n = 0; n < 2000 && u_dcf_reader.got.size() < exp_q.size(); n++) @(negedge clk);
      chk("read_count", DATA_W'(exp_q.size()), DATA_W'(u_dcf_reader.got.size()));
      foreach (exp_q[i]) chk("read_word", exp_q[i], u_dcf_reader.got[i]);
      flags(2'b01);
      chk("b_drive_ready", '0, DATA_W'({b_oe_n, orr}));
    end
    print_verdict();
  end
endmodule
